// *** shared/aspc_pkg.sv ***
// package: command codes, widths and states of the speed pattern sequencer
package aspc_pkg;
   localparam logic [7:0] CMD_LOW_START   = 8'h50;
   localparam logic [7:0] CMD_HIGH_START  = 8'h51;
   localparam logic [7:0] CMD_RAMP1_START = 8'h52;
   localparam logic [7:0] CMD_RAMP2_START = 8'h53;
   localparam logic [7:0] CMD_IMM_STOP    = 8'h49;
   localparam logic [7:0] CMD_DEC_STOP    = 8'h4A;
   localparam int         SPEED_W         = 16;
   localparam int         COUNT_W         = 24;
   localparam int         IDLE_W          = 8;
   localparam int         ACC_W           = 24;
   localparam int         MANUAL_SEL_BIT  = 13;
   localparam logic [SPEED_W-1:0] RATE_STEP_RESET = 16'h0001;
   localparam logic [COUNT_W-1:0] COUNT_RESET     = 24'h000000;

   typedef enum logic [2:0] {
      ASPC_IDLE   = 3'b000,
      ASPC_WARMUP = 3'b001,
      ASPC_ACCEL  = 3'b011,
      ASPC_CRUISE = 3'b010,
      ASPC_DECEL  = 3'b110
   } aspc_state_t;
endpackage : aspc_pkg

// *** hw/aspc_axis.sv ***
// axis speed pattern sequencer: commands to a pulse train
`timescale 1ns/1ps
module aspc_axis
   import aspc_pkg::*;
#(
   parameter int SPEED_WIDTH = aspc_pkg::SPEED_W,
   parameter int COUNT_WIDTH = aspc_pkg::COUNT_W
) (
   input  wire logic                          i_clock,
   input  wire logic                          i_rst,
   input  wire logic                          i_cmd_write,
   input  wire logic [7:0]                    i_cmd_code,
   input  wire logic                          i_positioning_mode,
   input  wire logic [15:0]                   i_operation_mode_prereg,
   input  wire logic [aspc_pkg::SPEED_W-1:0]  i_start_speed_reg,
   input  wire logic [aspc_pkg::SPEED_W-1:0]  i_main_speed_reg,
   input  wire logic [aspc_pkg::SPEED_W-1:0]  i_rate_step,
   input  wire logic [aspc_pkg::COUNT_W-1:0]  i_position_count,
   input  wire logic [aspc_pkg::COUNT_W-1:0]  i_ramp_down_point_prereg,
   input  wire logic [aspc_pkg::IDLE_W-1:0]   i_warmup_pulse_count,
   output logic                               o_pulse,
   output logic                               o_busy,
   output logic [aspc_pkg::SPEED_W-1:0]       o_speed,
   output logic [aspc_pkg::COUNT_W-1:0]       o_remaining,
   output aspc_pkg::aspc_state_t              o_state
);
   import aspc_pkg::*;

   aspc_state_t            state;
   logic [SPEED_W-1:0]     speed;
   logic [COUNT_W-1:0]     remaining;
   logic [IDLE_W-1:0]      warmup_left;
   logic [ACC_W-1:0]       phase_acc;
   logic                   positioning;
   logic                   ramp_auto_stop;
   logic                   pulse;
   logic                   is_start;
   logic                   is_imm;
   logic                   is_dec;
   logic                   last_pulse;
   logic                   ramp_hit;
   logic                   manual_ramp;
   logic [ACC_W-1:0]       next_acc;
   logic [SPEED_W:0]       accel_sum;
   logic [SPEED_W:0]       decel_floor;

   assign is_imm = i_cmd_write && i_cmd_code == CMD_IMM_STOP;
   assign is_dec = i_cmd_write && i_cmd_code == CMD_DEC_STOP;
   assign is_start = i_cmd_write && state == ASPC_IDLE &&
      (i_cmd_code == CMD_LOW_START || i_cmd_code == CMD_HIGH_START ||
       i_cmd_code == CMD_RAMP1_START || i_cmd_code == CMD_RAMP2_START);

   ////////////////////////////////////////////////////////////////////////
   // pulse generation: phase accumulator at the present speed
   assign next_acc = phase_acc + {{(ACC_W-SPEED_W){1'b0}}, speed};
   assign pulse = state != ASPC_IDLE && next_acc < phase_acc;
   assign last_pulse = positioning && pulse &&
      remaining == {{(COUNT_W-1){1'b0}}, 1'b1};
   // positioning count exhausted ends the feed
   // ramp point compare against pulses left
   assign ramp_hit = positioning && ramp_auto_stop &&
      remaining <= i_ramp_down_point_prereg;
   // 52h forces the manual ramp point
   assign manual_ramp = i_cmd_code == CMD_RAMP1_START ||
      i_operation_mode_prereg[MANUAL_SEL_BIT];
   // spare top bit: a sum near full scale must not wrap
   assign accel_sum   = {1'b0, speed} + {1'b0, i_rate_step};
   assign decel_floor = {1'b0, i_start_speed_reg} + {1'b0, i_rate_step};

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         phase_acc <= '0;
      end else if (state == ASPC_IDLE) begin
         phase_acc <= '0;
      end else begin
         phase_acc <= next_acc;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         remaining <= COUNT_RESET;
      end else if (is_start) begin
         remaining <= i_position_count;
      end else if (pulse && remaining != COUNT_RESET) begin
         remaining <= remaining - 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         warmup_left <= '0;
      end else if (is_start) begin
         warmup_left <= i_warmup_pulse_count;
      end else if (state == ASPC_WARMUP && pulse) begin
         warmup_left <= warmup_left - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pattern sequencer
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state          <= ASPC_IDLE;
         speed          <= '0;
         positioning    <= 1'b0;
         ramp_auto_stop <= 1'b0;
      end else begin
         case (state)
            ASPC_IDLE: begin
               if (is_start) begin
                  positioning <= i_positioning_mode;
                  ramp_auto_stop <= 1'b0;
                  case (i_cmd_code)
                     CMD_LOW_START: begin
                        speed <= i_start_speed_reg;
                        state <= ASPC_CRUISE;
                     end
                     CMD_HIGH_START: begin
                        speed <= i_main_speed_reg;
                        state <= ASPC_CRUISE;
                     end
                     default: begin
                        speed <= i_start_speed_reg;
                        ramp_auto_stop <= 1'b1;
                        if (i_positioning_mode && manual_ramp &&
                            i_ramp_down_point_prereg == COUNT_RESET) begin
                           state <= ASPC_IDLE;
                        end else if (i_warmup_pulse_count != '0) begin
                           state <= ASPC_WARMUP;
                        end else begin
                           state <= ASPC_ACCEL;
                        end
                     end
                  endcase
               end
            end
            default: begin
               if (is_imm || last_pulse ||
                   (positioning && remaining == COUNT_RESET)) begin
                  state <= ASPC_IDLE;
                  speed <= '0;
               end else if (is_dec) begin
                  if (speed <= i_start_speed_reg) begin
                     state <= ASPC_IDLE;
                     speed <= '0;
                  end else begin
                     state <= ASPC_DECEL;
                  end
               end else if (state != ASPC_DECEL && ramp_hit) begin
                  state <= ASPC_DECEL;
               end else begin
                  case (state)
                     ASPC_WARMUP: begin
                        if (pulse && warmup_left == 8'h01) begin
                           state <= ASPC_ACCEL;
                        end
                     end
                     ASPC_ACCEL: begin
                        if (accel_sum >= {1'b0, i_main_speed_reg}) begin
                           speed <= i_main_speed_reg;
                           state <= ASPC_CRUISE;
                        end else begin
                           speed <= accel_sum[SPEED_W-1:0];
                        end
                     end
                     ASPC_DECEL: begin
                        if ({1'b0, speed} <= decel_floor) begin
                           speed <= i_start_speed_reg;
                           // continuous decel ends at start speed
                           if (!positioning) begin
                              state <= ASPC_IDLE;
                              speed <= '0;
                           end
                        end else begin
                           speed <= speed - i_rate_step;
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pulse <= 1'b0;
      end else begin
         o_pulse <= pulse;
      end
   end

   assign o_busy      = state != ASPC_IDLE;
   assign o_speed     = speed;
   assign o_remaining = remaining;
   assign o_state     = state;

   ////////////////////////////////////////////////////////////////////////
   // checks
   // immediate stop halts
   a_imm_stop_halts: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state != ASPC_IDLE && is_imm |=> state == ASPC_IDLE)
      else $error("immediate stop did not halt");
   a_low_start_speed: assert property (
      @(posedge i_clock) disable iff (i_rst)
      is_start && i_cmd_code == CMD_LOW_START |=>
      speed == $past(i_start_speed_reg) && state == ASPC_CRUISE)
      else $error("low start wrong speed");
   a_high_start_speed: assert property (
      @(posedge i_clock) disable iff (i_rst)
      is_start && i_cmd_code == CMD_HIGH_START |=>
      speed == $past(i_main_speed_reg))
      else $error("high start wrong speed");
   a_dec_no_halt: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state == ASPC_CRUISE && is_dec && !is_imm && !last_pulse &&
      speed > i_start_speed_reg && !(positioning && remaining == '0)
      |=> state == ASPC_DECEL)
      else $error("decelerating stop did not decelerate");
   a_count_end_stop: assert property (
      @(posedge i_clock) disable iff (i_rst)
      last_pulse |=> state == ASPC_IDLE)
      else $error("count exhausted but still running");
   a_warmup_first: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state == ASPC_WARMUP |-> speed == i_start_speed_reg ||
      $changed(i_start_speed_reg))
      else $error("warmup not at start speed");
   a_ramp_start: assert property (
      @(posedge i_clock) disable iff (i_rst)
      is_start && i_cmd_code == CMD_RAMP1_START |=>
      speed == $past(i_start_speed_reg))
      else $error("ramped run not from start speed");
   a_zero_ramp_stop: assert property (
      @(posedge i_clock) disable iff (i_rst)
      is_start && i_positioning_mode && i_ramp_down_point_prereg == '0 &&
      (i_cmd_code == CMD_RAMP1_START || (i_cmd_code == CMD_RAMP2_START &&
      i_operation_mode_prereg[MANUAL_SEL_BIT])) |=> state == ASPC_IDLE)
      else $error("zero ramp point did not stop");
   a_idle_silent: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state == ASPC_IDLE && !is_start |=> !o_pulse)
      else $error("pulse while stopped");
   // low speed run stops on 4Ah
   a_low_dec_stop: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state == ASPC_CRUISE && is_dec && speed <= i_start_speed_reg
      |=> state == ASPC_IDLE)
      else $error("low speed run kept going");
   a_zero_count_stop: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state != ASPC_IDLE && positioning && remaining == '0
      |=> state == ASPC_IDLE)
      else $error("empty count kept running");
   a_count_steps: assert property (
      @(posedge i_clock) disable iff (i_rst)
      pulse && positioning && remaining != '0
      |=> remaining == $past(remaining) - 24'h000001)
      else $error("positioning count missed a pulse");
   a_warmup_count: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state == ASPC_WARMUP ##1 state == ASPC_ACCEL
      |-> $past(pulse) && $past(warmup_left) == 8'h01)
      else $error("warmup ended early");
   // ramp climbs by the rate step
   a_accel_steps: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state == ASPC_ACCEL && !is_imm && !is_dec && !ramp_hit &&
      !last_pulse && !(positioning && remaining == '0)
      |=> state == ASPC_CRUISE ||
      speed == $past(speed) + $past(i_rate_step))
      else $error("ramp did not climb");
   a_ramp_point_decel: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state inside {ASPC_WARMUP, ASPC_ACCEL, ASPC_CRUISE} && ramp_hit &&
      !is_imm && !is_dec && !last_pulse && !(positioning && remaining == '0)
      |=> state == ASPC_DECEL)
      else $error("ramp point passed without deceleration");
   a_decel_floor: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state == ASPC_DECEL && $past(state) == ASPC_DECEL &&
      $stable(i_start_speed_reg) |-> speed >= i_start_speed_reg)
      else $error("deceleration fell below start speed");
   // idle codes other than starts ignored
   a_idle_holds: assert property (
      @(posedge i_clock) disable iff (i_rst)
      state == ASPC_IDLE && !is_start |=> state == ASPC_IDLE)
      else $error("left idle without a start");
endmodule : aspc_axis

// *** testbench/aspc_drive_model.sv ***
// motor driver side model: counts the step pulses the axis sends out
`timescale 1ns/1ps
module aspc_drive_model (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_clear,
   input  wire logic        i_pulse,
   output logic [23:0]      o_count
);
   ////////////////////////////////////////////////////////////////////////
   // every step outside a clear cycle is counted, cleared per test
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_count <= 24'h000000;
      end else if (i_clear) begin
         o_count <= 24'h000000;
      end else if (i_pulse) begin
         o_count <= o_count + 24'h000001;
      end
   end
endmodule : aspc_drive_model

// *** testbench/tb_aspc_axis.sv ***
// testbench for the axis speed pattern sequencer
`timescale 1ns/1ps
module tb_aspc_axis;
   import aspc_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, pos = 1'b0, clr = 1'b0;
   logic [7:0]  code = 8'h00;
   logic [15:0] mode = 16'h0000, fl = 16'h8000, fh = 16'hFFFF;
   logic [15:0] step = 16'h0100, speed;
   logic [23:0] cnt = 24'h000000, rdp = 24'h000000, rem, seen;
   logic [7:0]  warmup_pulse_count = 8'h00;
   logic        pulse, busy;
   aspc_state_t st;
   int          n_mismatch = 0, check_count = 0;
   ////////////////////////////////////////////////////////////////////////
   aspc_axis i_aspc_axis (.i_clock(clk), .i_rst(rst), .i_cmd_write(wr),
      .i_cmd_code(code), .i_positioning_mode(pos),
      .i_operation_mode_prereg(mode), .i_start_speed_reg(fl),
      .i_main_speed_reg(fh), .i_rate_step(step), .i_position_count(cnt),
      .i_ramp_down_point_prereg(rdp), .i_warmup_pulse_count(warmup_pulse_count),
      .o_pulse(pulse), .o_busy(busy), .o_speed(speed), .o_remaining(rem),
      .o_state(st));
   aspc_drive_model i_aspc_drive_model (.i_clock(clk), .i_rst(rst),
      .i_clear(clr), .i_pulse(pulse), .o_count(seen));
   initial begin
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   // one strobe, then let the answer land
   task automatic cmd(logic [7:0] c);
      @(negedge clk) wr = 1'b1;
      code = c;
      @(negedge clk) wr = 1'b0;
      @(negedge clk);
   endtask : cmd
   task automatic wait_st(aspc_state_t s);
      int k;
      for (k = 0; k < 20000 && st !== s; k++) @(negedge clk);
      if (st !== s) begin
         n_mismatch++;
         $display("Error wait for state %0d timed out", s);
         stop_test();
      end
   endtask : wait_st
   task automatic fresh(logic p, logic [23:0] c, logic [23:0] r);
      @(negedge clk) clr = 1'b1;
      pos = p;
      cnt = c;
      rdp = r;
      @(negedge clk) clr = 1'b0;
   endtask : fresh
   ////////////////////////////////////////////////////////////////////////
   task automatic t_low();
      fresh(1'b0, 24'h000000, 24'h000000);
      cmd(CMD_LOW_START);
      check("low busy", busy, 1);
      check("low speed", speed, fl);
      cmd(CMD_IMM_STOP);
      check("imm stop busy", busy, 0);
      cmd(CMD_LOW_START);
      cmd(CMD_DEC_STOP);
      check("dec stop busy", busy, 0);
      check("stop speed", speed, 0);
      $display("test low speed done");
   endtask : t_low
   task automatic t_high();
      fresh(1'b0, 24'h000000, 24'h000000);
      cmd(CMD_HIGH_START);
      check("high speed", speed, fh);
      cmd(CMD_DEC_STOP);
      check("high dec busy", busy, 1);
      check("high dec state", st, ASPC_DECEL);
      wait_st(ASPC_IDLE);
      $display("test high speed done");
   endtask : t_high
   task automatic t_ramp1();
      fresh(1'b0, 24'h000000, 24'h000000);
      warmup_pulse_count = 8'h03;
      cmd(CMD_RAMP1_START);
      check("warmup state", st, ASPC_WARMUP);
      check("warmup speed", speed, fl);
      wait_st(ASPC_ACCEL);
      repeat (2) @(negedge clk);
      check("warmup pulses", seen, 24'h000003);
      wait_st(ASPC_CRUISE);
      check("cruise speed", speed, fh);
      cmd(CMD_IMM_STOP);
      check("ramp imm stop", busy, 0);
      warmup_pulse_count = 8'h00;
      $display("test ramp one done");
   endtask : t_ramp1
   task automatic t_ramp2();
      fresh(1'b1, 24'h000028, 24'h00000A);
      mode = 16'h0000;
      cmd(CMD_RAMP2_START);
      wait_st(ASPC_DECEL);
      check("decel at point", rem <= 24'h00000A, 1);
      wait_st(ASPC_IDLE);
      repeat (2) @(negedge clk);
      check("position pulses", seen, 24'h000028);
      fresh(1'b0, 24'h000000, 24'h000000);
      cmd(CMD_RAMP2_START);
      wait_st(ASPC_CRUISE);
      cmd(CMD_DEC_STOP);
      check("ramp two dec", st, ASPC_DECEL);
      wait_st(ASPC_IDLE);
      $display("test ramp two done");
   endtask : t_ramp2
   task automatic t_refused();
      fresh(1'b1, 24'h000010, 24'h000000);
      cmd(CMD_RAMP1_START);
      check("auto bit ignored", busy, 0);
      mode = 16'h2000;
      cmd(CMD_RAMP2_START);
      check("zero point stop", busy, 0);
      mode = 16'h0000;
      cmd(CMD_RAMP2_START);
      check("auto point runs", busy, 1);
      cmd(CMD_IMM_STOP);
      check("auto imm stop", busy, 0);
      cmd(CMD_DEC_STOP);
      cmd(CMD_IMM_STOP);
      cmd(8'h00);
      check("idle stop busy", busy, 0);
      check("idle stop speed", speed, 0);
      check("idle pulses", seen, 0);
      $display("test refused codes done");
   endtask : t_refused
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      t_low();
      t_high();
      t_ramp1();
      t_ramp2();
      t_refused();
      stop_test();
   end
endmodule : tb_aspc_axis
